// *** smtr_pkg.sv ***
// Constants, types and helpers shared by the SMBus temperature register slave
// Operation
// RL1 - Four byte protocols, address, command, data, acks
// RL2 - All state seen as byte-wide registers
// RL3 - Command byte selects register for write/read
// RL4 - Receive byte returns last selected register
// RL5 - Multi-master hosts avoid short send/receive forms
// RL6 - Respond on any of nine slave addresses
// RL7 - Temperatures readable at commands 00h, 01h
// RL8 - Unsigned byte, LSB 1 degree, MSB 128
// RL9 - Read data shifted out MSB first
// RL10 - Negative temperatures stored and reported as zero
// RL11 - Local low byte holds three fraction bits
// RL12 - Address chosen from two select pins
// RL13 - Pointer persists, resets to register zero
// RL14 - Drive and ack only on own address
package smtr_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_TEMP_A      = 8'h00;
   localparam logic [7:0] REG_TEMP_B      = 8'h01;
   localparam logic [7:0] REG_TEMP_A_FRAC = 8'h10;
   localparam logic [7:0] PTR_RESET       = 8'h00;
   localparam logic [7:0] TEMP_RESET      = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

   // ----------------------------------------------------------------------
   // Frame layout and timing
   // ----------------------------------------------------------------------
   localparam int         ADDR_W        = 7;
   localparam int         RW_POS        = 0;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int         CLK_HZ        = 20_000_000;
   localparam int         T_HOLD_NS     = 300;
   // Least hold time, rounded up to whole cycles
   localparam int         HOLD_CYC      = (T_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [3:0] HOLD_CNT      = 4'(HOLD_CYC);

   // ----------------------------------------------------------------------
   // Address select pins: each pin is low, high or left open
   // ----------------------------------------------------------------------
   localparam logic [1:0]        PIN_LOW   = 2'h0;
   localparam logic [1:0]        PIN_HIGH  = 2'h1;
   localparam logic [ADDR_W-1:0] ADDR_BASE = 7'h18;

   // ----------------------------------------------------------------------
   // Temperature sample: signed, eighths of a degree
   // ----------------------------------------------------------------------
   localparam int TEMP_W = 12;
   localparam int FRAC_W = 3;

   typedef struct packed {
      logic                     valid;
      logic signed [TEMP_W-1:0] chan_a;
      logic signed [TEMP_W-1:0] chan_b;
   } smtr_temp_t;

   function automatic logic [3:0] smtr_pin_rank(input logic [1:0] code);
      return (code == PIN_LOW) ? 4'h0 : (code == PIN_HIGH) ? 4'h1 : 4'h2;
   endfunction

   function automatic logic [ADDR_W-1:0] smtr_slave_addr(input logic [1:0] lo,
                                                         input logic [1:0] hi);
      logic [3:0] idx;
      idx = 4'h3 * smtr_pin_rank(hi) + smtr_pin_rank(lo);
      return ADDR_BASE + 7'(idx);  // RL6
   endfunction

   function automatic logic [7:0] smtr_clip_whole(input logic signed [TEMP_W-1:0] t);
      return t[TEMP_W-1] ? 8'h00 : t[TEMP_W-2:FRAC_W];
   endfunction

   function automatic logic [7:0] smtr_clip_frac(input logic signed [TEMP_W-1:0] t);
      return t[TEMP_W-1] ? 8'h00 : {t[FRAC_W-1:0], 5'h00};
   endfunction

endpackage

// *** smtr_temp_store.sv ***
// Temperature register store with negative clipping and read mux
`timescale 1ns/1ps
module smtr_temp_store
(
   input  wire logic              clk_sys_i,  // System clock
   input  wire logic              rstn_i,     // Async reset, active low
   input  wire logic              ce_i,       // Clock enable
   input  wire smtr_pkg::smtr_temp_t temp_i,  // New sample from converter
   input  wire logic [7:0]        rd_idx_i,   // Register pointer
   output logic      [7:0]        rd_data_o   // Selected register byte
);

   logic [7:0] a_hi_q, a_hi_d;
   logic [7:0] a_lo_q, a_lo_d;
   logic [7:0] b_hi_q, b_hi_d;

   // ----------------------------------------------------------------------
   // Sample capture
   // ----------------------------------------------------------------------
   // Clip before storing so a read can never see a wrapped code
   always_comb
   begin
      a_hi_d = a_hi_q;
      a_lo_d = a_lo_q;
      b_hi_d = b_hi_q;
      if (temp_i.valid)
      begin
         a_hi_d = smtr_pkg::smtr_clip_whole(temp_i.chan_a);  // RL8
         a_lo_d = smtr_pkg::smtr_clip_frac(temp_i.chan_a);   // RL11
         b_hi_d = smtr_pkg::smtr_clip_whole(temp_i.chan_b);  // RL10
      end
   end

   // Registers update only while enabled
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         a_hi_q <= smtr_pkg::TEMP_RESET;
         a_lo_q <= smtr_pkg::TEMP_RESET;
         b_hi_q <= smtr_pkg::TEMP_RESET;
      end
      else if (ce_i)
      begin
         a_hi_q <= a_hi_d;
         a_lo_q <= a_lo_d;
         b_hi_q <= b_hi_d;
      end
   end

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   // Every register is one byte; unmapped pointers read a fixed value
   always_comb
   begin
      unique case (rd_idx_i)
         smtr_pkg::REG_TEMP_A:      rd_data_o = a_hi_q;  // RL7
         smtr_pkg::REG_TEMP_B:      rd_data_o = b_hi_q;  // RL7
         smtr_pkg::REG_TEMP_A_FRAC: rd_data_o = a_lo_q;  // RL2
         default:                   rd_data_o = smtr_pkg::UNMAPPED_DATA;
      endcase
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   neg_clip_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL10
      (ce_i && temp_i.valid && temp_i.chan_b < 0) |=> (b_hi_q == 8'h00 && $past(ce_i)))
      else $error("negative channel b not clipped");
   whole_deg_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL8
      (ce_i && temp_i.valid && temp_i.chan_a >= 0) |=> a_hi_q == $past(temp_i.chan_a[10:3]))
      else $error("channel a whole degrees wrong");
   frac_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL11
      (ce_i && temp_i.valid && temp_i.chan_a >= 0)
      |=> a_lo_q == {$past(temp_i.chan_a[2:0]), 5'h00})
      else $error("channel a fraction byte wrong");
   temp_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL2
      !(ce_i && temp_i.valid) |=> $stable(a_hi_q) && $stable(b_hi_q))
      else $error("temperature changed without a sample");

endmodule

// *** smtr_smbus_slave.sv ***
// SMBus slave engine serving the temperature registers
`timescale 1ns/1ps
module smtr_smbus_slave
(
   input  wire logic              clk_sys_i,               // System clock, 20 MHz
   input  wire logic              rstn_i,                  // Async reset, active low
   input  wire logic              ce_i,                    // Clock enable, freezes all state
   input  wire logic              scl_i,                   // Bus clock pin
   input  wire logic              sda_i,                   // Bus data pin level
   output logic                   sda_o,                   // Data drive level, always low
   output logic                   sda_oen_o,               // Data enable, low drives the pin
   input  wire logic [1:0]        slave_addr_select_lo_i,  // Select pin lo: low/high/open
   input  wire logic [1:0]        slave_addr_select_hi_i,  // Select pin hi: low/high/open
   input  wire smtr_pkg::smtr_temp_t temp_i,               // Converter samples
   output logic      [7:0]        reg_ptr_o,               // Current register pointer
   output logic      [6:0]        own_addr_o               // Selected slave address
);

   typedef enum {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK,
      S_WDATA, S_WACK, S_RDATA, S_RACK, S_IGNORE
   } smtr_state_t;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic       scl_meta_q, scl_sync_q, scl_prev_q;
   logic       sda_meta_q, sda_sync_q, sda_prev_q;
   logic [1:0] sel_lo_meta_q, sel_lo_sync_q;
   logic [1:0] sel_hi_meta_q, sel_hi_sync_q;

   // Two flops per pin; edge logic looks only at the second and its copy
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         scl_meta_q    <= 1'b1;
         scl_sync_q    <= 1'b1;
         scl_prev_q    <= 1'b1;
         sda_meta_q    <= 1'b1;
         sda_sync_q    <= 1'b1;
         sda_prev_q    <= 1'b1;
         sel_lo_meta_q <= 2'h0;
         sel_lo_sync_q <= 2'h0;
         sel_hi_meta_q <= 2'h0;
         sel_hi_sync_q <= 2'h0;
      end
      else if (ce_i)
      begin
         scl_meta_q    <= scl_i;
         scl_sync_q    <= scl_meta_q;
         scl_prev_q    <= scl_sync_q;
         sda_meta_q    <= sda_i;
         sda_sync_q    <= sda_meta_q;
         sda_prev_q    <= sda_sync_q;
         sel_lo_meta_q <= slave_addr_select_lo_i;
         sel_lo_sync_q <= sel_lo_meta_q;
         sel_hi_meta_q <= slave_addr_select_hi_i;
         sel_hi_sync_q <= sel_hi_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // Address strap capture
   // ----------------------------------------------------------------------
   logic [1:0] cap_cnt_q, cap_cnt_d;
   logic [6:0] own_addr_q, own_addr_d;
   logic       caught_q, caught_d;

   // Pins are caught once, after the synchronisers have filled
   always_comb
   begin
      cap_cnt_d  = cap_cnt_q;
      own_addr_d = own_addr_q;
      caught_d   = caught_q;
      if (!caught_q)
      begin
         cap_cnt_d = cap_cnt_q + 2'h1;
         if (cap_cnt_q == 2'h2)
         begin
            own_addr_d = smtr_pkg::smtr_slave_addr(sel_lo_sync_q, sel_hi_sync_q); // RL12
            caught_d   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         cap_cnt_q  <= 2'h0;
         own_addr_q <= smtr_pkg::ADDR_BASE;
         caught_q   <= 1'b0;
      end
      else if (ce_i)
      begin
         cap_cnt_q  <= cap_cnt_d;
         own_addr_q <= own_addr_d;
         caught_q   <= caught_d;
      end
   end

   // ----------------------------------------------------------------------
   // Bus events
   // ----------------------------------------------------------------------
   logic        rise_ev, fall_raw, start_ev, stop_ev, fall_ev;
   logic [3:0]  hold_q, hold_d;
   logic [7:0]  rd_data;

   // Start and stop are data edges while the clock stays high
   assign rise_ev  = scl_sync_q & ~scl_prev_q;
   assign fall_raw = ~scl_sync_q & scl_prev_q;
   assign start_ev = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
   assign stop_ev  = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;
   // Data changes wait out the hold time after the clock falls
   assign fall_ev  = (hold_q == 4'h1);

   // ----------------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------------
   smtr_state_t state_q, state_d;
   logic [3:0]  cnt_q, cnt_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  tx_q, tx_d;
   logic [7:0]  ptr_q, ptr_d;
   logic        rw_q, rw_d;
   logic        have_cmd_q, have_cmd_d;
   logic        acked_q, acked_d;
   logic        sda_oen_q, sda_oen_d;
   logic        addr_hit;

   assign addr_hit = caught_q && (shift_q[7:1] == own_addr_q);

   // One frame walks address, optional command, then data bytes
   always_comb
   begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      shift_d    = shift_q;
      tx_d       = tx_q;
      ptr_d      = ptr_q;
      rw_d       = rw_q;
      have_cmd_d = have_cmd_q;
      acked_d    = acked_q;
      sda_oen_d  = sda_oen_q;
      hold_d     = (hold_q != 4'h0) ? hold_q - 4'h1 : hold_q;
      if (fall_raw)
         hold_d = smtr_pkg::HOLD_CNT;
      if (start_ev)
      begin
         // A repeated start keeps the pointer for the read that follows
         state_d    = S_ADDR;
         cnt_d      = 4'h0;
         have_cmd_d = 1'b0;
         sda_oen_d  = 1'b1;
         hold_d     = 4'h0;
      end
      else if (stop_ev)
      begin
         state_d   = S_IDLE;
         sda_oen_d = 1'b1;
         hold_d    = 4'h0;
      end
      else
      begin
         if (rise_ev && cnt_q < smtr_pkg::BITS_PER_BYTE)
         begin
            shift_d = {shift_q[6:0], sda_sync_q};  // RL1
            cnt_d   = cnt_q + 4'h1;
         end
         if (rise_ev && state_q == S_RACK)
            acked_d = ~sda_sync_q;
         if (fall_ev)
         begin
            unique case (state_q)
               S_ADDR:
                  if (cnt_q == smtr_pkg::BITS_PER_BYTE)
                  begin
                     if (addr_hit)
                     begin
                        state_d   = S_ADDR_ACK;
                        rw_d      = shift_q[smtr_pkg::RW_POS];
                        sda_oen_d = 1'b0;  // RL14
                     end
                     else
                        state_d = S_IGNORE;  // RL14
                  end
               S_ADDR_ACK:
               begin
                  cnt_d = 4'h0;
                  if (rw_q)
                  begin
                     // Read byte and receive byte both use the held pointer
                     tx_d      = rd_data;  // RL4
                     sda_oen_d = rd_data[7];  // RL9
                     state_d   = S_RDATA;
                  end
                  else
                  begin
                     sda_oen_d = 1'b1;
                     state_d   = have_cmd_q ? S_WDATA : S_CMD;
                  end
               end
               S_CMD:
                  if (cnt_q == smtr_pkg::BITS_PER_BYTE)
                  begin
                     ptr_d      = shift_q;  // RL3
                     have_cmd_d = 1'b1;
                     sda_oen_d  = 1'b0;
                     state_d    = S_CMD_ACK;
                  end
               S_CMD_ACK, S_WACK:
               begin
                  cnt_d     = 4'h0;
                  sda_oen_d = 1'b1;
                  state_d   = S_WDATA;
               end
               S_WDATA:
                  // All mapped registers are read-only; the byte is acked and dropped
                  if (cnt_q == smtr_pkg::BITS_PER_BYTE)
                  begin
                     sda_oen_d = 1'b0;
                     state_d   = S_WACK;
                  end
               S_RDATA:
                  if (cnt_q == smtr_pkg::BITS_PER_BYTE)
                  begin
                     sda_oen_d = 1'b1;
                     state_d   = S_RACK;
                  end
                  else
                     sda_oen_d = tx_q[3'h7 - cnt_q[2:0]];  // RL9
               S_RACK:
                  if (acked_q)
                  begin
                     tx_d      = rd_data;
                     sda_oen_d = rd_data[7];
                     cnt_d     = 4'h0;
                     state_d   = S_RDATA;
                  end
                  else
                     state_d = S_IGNORE;
               S_IDLE, S_IGNORE:
                  sda_oen_d = 1'b1;
            endcase
         end
      end
   end

   // Pointer survives stop and restart; only a command byte moves it
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         state_q    <= S_IDLE;
         cnt_q      <= 4'h0;
         shift_q    <= 8'h00;
         tx_q       <= 8'h00;
         ptr_q      <= smtr_pkg::PTR_RESET;  // RL13
         rw_q       <= 1'b0;
         have_cmd_q <= 1'b0;
         acked_q    <= 1'b0;
         sda_oen_q  <= 1'b1;
         hold_q     <= 4'h0;
      end
      else if (ce_i)
      begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         shift_q    <= shift_d;
         tx_q       <= tx_d;
         ptr_q      <= ptr_d;
         rw_q       <= rw_d;
         have_cmd_q <= have_cmd_d;
         acked_q    <= acked_d;
         sda_oen_q  <= sda_oen_d;
         hold_q     <= hold_d;
      end
   end

   // ----------------------------------------------------------------------
   // Register store and outputs
   // ----------------------------------------------------------------------
   smtr_temp_store u_store
   (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .ce_i      (ce_i),
      .temp_i    (temp_i),
      .rd_idx_i  (ptr_q),
      .rd_data_o (rd_data)
   );

   // Open drain: the level is fixed low, only the enable toggles
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         sda_o <= 1'b0;
      else if (ce_i)
         sda_o <= 1'b0;
   end

   assign sda_oen_o  = sda_oen_q;
   assign reg_ptr_o  = ptr_q;
   assign own_addr_o = own_addr_q;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   ignore_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL14
      (state_q == S_IGNORE || state_q == S_IDLE) |-> sda_oen_q)
      else $error("data driven while not addressed");
   addr_ack_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL6
      (ce_i && fall_ev && state_q == S_ADDR && cnt_q == 4'h8 && !start_ev && !stop_ev)
      |=> (sda_oen_q == !$past(addr_hit)))
      else $error("address ack does not follow match");
   cmd_load_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL3
      (ce_i && fall_ev && state_q == S_CMD && cnt_q == 4'h8 && !start_ev && !stop_ev)
      |=> ptr_q == $past(shift_q) ##1 1'b1)
      else $error("command byte not loaded into pointer");
   ptr_keep_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL13
      (state_q != S_CMD) |=> $stable(ptr_q))
      else $error("pointer moved outside a command byte");
   read_load_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL4
      (ce_i && fall_ev && state_q == S_ADDR_ACK && rw_q && !start_ev && !stop_ev)
      |=> tx_q == $past(rd_data) && sda_oen_q == $past(rd_data[7]))
      else $error("read byte not loaded from pointer");
   msb_first_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL9
      (ce_i && fall_ev && state_q == S_RDATA && cnt_q < 4'h8 && !start_ev && !stop_ev)
      |=> sda_oen_q == $past(tx_q[3'h7 - cnt_q[2:0]]))
      else $error("read bit order wrong");
   addr_stable_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL12
      caught_q |=> $stable(own_addr_q) && caught_q)
      else $error("slave address changed after capture");
   ack_turn_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // RL1
      (ce_i && fall_ev && state_q == S_CMD_ACK && !start_ev && !stop_ev)
      |=> state_q == S_WDATA && sda_oen_q && cnt_q == 4'h0)
      else $error("command ack did not release the line");

endmodule

// *** smtr_host_model.sv ***
// SMBus host model that drives the bus side of the slave
`timescale 1ns/1ps
module smtr_host_model
(
   input  wire logic clk_sys_i,  // System clock
   input  wire logic sda_i,      // Wired data level
   output logic      scl_o,      // Bus clock, idles high
   output logic      sda_o       // Data drive, 1 releases
);
   // Bus idles released and high
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // Quarter bit of 25 cycles keeps scl low well over the device hold time
   task automatic step;
      repeat (25) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic start;
      sda_o = 1'b1;
      step;
      scl_o = 1'b1;
      step;
      sda_o = 1'b0;
      step;
      scl_o = 1'b0;
   endtask

   task automatic stop;
      step;
      sda_o = 1'b0;
      step;
      scl_o = 1'b1;
      step;
      sda_o = 1'b1;
      step;
   endtask

   // Data changes only while scl is low, sampled mid high
   task automatic xbit(input logic b, output logic r);
      step;
      sda_o = b;
      step;
      scl_o = 1'b1;
      step;
      r = sda_i;
      step;
      scl_o = 1'b0;
   endtask

   // Eight bits MSB first, then the ninth bit for the ack
   task automatic xbyte(input logic [7:0] d, input logic l, output logic [7:0] r,
                        output logic ack);
      for (int i = 7; i >= 0; i--)
      begin
         xbit(d[i], r[i]);
      end
      xbit(l, ack);
   endtask

   // Write byte, or send byte when has_d is low; ack high if any byte refused
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic has_d,
                     input logic [7:0] d, output logic ack);
      logic [7:0] j;
      logic       k;
      start;
      xbyte({a, 1'b0}, 1'b1, j, ack);
      xbyte(c, 1'b1, j, k);
      ack |= k;
      if (has_d)
      begin
         xbyte(d, 1'b1, j, k);
         ack |= k;
      end
      stop;
   endtask

   // Read byte, or receive byte when has_c is low; single master, so the
   // short form cannot see the pointer moved by another host
   task automatic rd(input logic [6:0] a, input logic has_c, input logic [7:0] c,
                     output logic [7:0] r, output logic ack);
      logic [7:0] j;
      logic       k;
      ack = 1'b0;
      if (has_c)
      begin
         start;
         xbyte({a, 1'b0}, 1'b1, j, ack);
         xbyte(c, 1'b1, j, k);
         ack |= k;
      end
      start;
      xbyte({a, 1'b1}, 1'b1, j, k);
      ack |= k;
      xbyte(8'hff, 1'b1, r, k);
      stop;
   endtask

   // Receive byte read twice in one frame: ack the first, refuse the second
   task automatic rd2(input logic [6:0] a, output logic [7:0] r0, output logic [7:0] r1);
      logic [7:0] j;
      logic       k;
      start;
      xbyte({a, 1'b1}, 1'b1, j, k);
      xbyte(8'hff, 1'b0, r0, k);
      xbyte(8'hff, 1'b1, r1, k);
      stop;
   endtask
endmodule

// *** tb_smtr_smbus_slave.sv ***
// Self-checking bench for the SMBus temperature register slave
`timescale 1ns/1ps
module tb_smtr_smbus_slave;
   logic                 clk_sys_i, rstn_i, scl, host_sda, sda_o, sda_oen_o, sda_w, ack;
   logic [1:0]           sel_lo, sel_hi;
   logic [7:0]           reg_ptr, r, r2;
   logic [6:0]           own_addr;
   smtr_pkg::smtr_temp_t temp;
   int                   err_total = 0, total_checks = 0, pulls = 0;

   // Open-drain data wire with pull-up
   assign sda_w = host_sda & (sda_oen_o ? 1'b1 : sda_o);

   smtr_smbus_slave u_smtr_smbus_slave (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(1'b1),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oen_o(sda_oen_o),
      .slave_addr_select_lo_i(sel_lo), .slave_addr_select_hi_i(sel_hi), .temp_i(temp),
      .reg_ptr_o(reg_ptr), .own_addr_o(own_addr));
   smtr_host_model u_smtr_host_model (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl),
      .sda_o(host_sda));

   // 20 MHz clock
   initial
   begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // Count cycles in which the slave pulls the data line
   always @(posedge clk_sys_i)
   begin
      if (sda_oen_o === 1'b0) pulls++;
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d errors=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] lo, input logic [1:0] hi);
      @(posedge clk_sys_i);
      #1;
      rstn_i = 1'b0;
      sel_lo = lo;
      sel_hi = hi;
      repeat (6) @(posedge clk_sys_i);
      #1;
      chk({7'h0, sda_oen_o}, 8'h01);
      chk(reg_ptr, 8'h00);
      rstn_i = 1'b1;
      repeat (6) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic load(input logic [11:0] a, input logic [11:0] b);
      temp = {1'b1, a, b};
      @(posedge clk_sys_i);
      #1;
      temp.valid = 1'b0;
      @(posedge clk_sys_i);
      #1;
   endtask

   // Nine pin settings, then capture-once check
   task automatic t_addr;
      for (int h = 0; h < 3; h++)
      begin
         for (int l = 0; l < 3; l++)
         begin
            do_reset(2'(l), 2'(h));
            chk({1'b0, own_addr}, 8'(8'h18 + 3 * h + l));
         end
      end
      do_reset(2'h1, 2'h3);
      sel_lo = 2'h0;
      sel_hi = 2'h0;
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk({1'b0, own_addr}, 8'h1f);
   endtask

   // Read byte of both channels and the fraction byte
   task automatic t_read;
      logic [7:0] cmd [3] = '{8'h00, 8'h01, 8'h10};
      logic [7:0] exp [3] = '{8'h19, 8'h00, 8'h60};
      load(12'h0cb, 12'hff0);
      for (int i = 0; i < 3; i++)
      begin
         u_smtr_host_model.rd(7'h1f, 1'b1, cmd[i], r, ack);
         chk({7'h0, ack}, 8'h00);
         chk(r, exp[i]);
         chk(reg_ptr, cmd[i]);
      end
   endtask

   // Send byte then receive byte; a write leaves read-only data alone
   task automatic t_recv;
      load(12'h7ff, 12'h3f8);
      u_smtr_host_model.wr(7'h1f, 8'h01, 1'b0, 8'h00, ack);
      chk({7'h0, ack}, 8'h00);
      repeat (2)
      begin
         u_smtr_host_model.rd(7'h1f, 1'b0, 8'h00, r, ack);
         chk(r, 8'h7f);
      end
      // Host ack on a read byte hands out the same register again
      u_smtr_host_model.rd2(7'h1f, r, r2);
      chk(r, 8'h7f);
      chk(r2, 8'h7f);
      u_smtr_host_model.wr(7'h1f, 8'h00, 1'b1, 8'h55, ack);
      chk({7'h0, ack}, 8'h00);
      u_smtr_host_model.rd(7'h1f, 1'b0, 8'h00, r, ack);
      chk(r, 8'hff);
      u_smtr_host_model.rd(7'h1f, 1'b1, 8'h05, r, ack);
      chk(r, 8'h00);
   endtask

   // Frames to another address draw no ack and no drive
   task automatic t_foreign;
      pulls = 0;
      u_smtr_host_model.wr(7'h18, 8'h10, 1'b0, 8'h00, ack);
      chk({7'h0, ack}, 8'h01);
      u_smtr_host_model.rd(7'h18, 1'b1, 8'h01, r, ack);
      chk({7'h0, ack}, 8'h01);
      chk({7'h0, pulls != 0}, 8'h00);
      chk(reg_ptr, 8'h05);
   endtask

   // Main sequence
   initial
   begin
      rstn_i = 1'b0;
      sel_lo = 2'h0;
      sel_hi = 2'h0;
      temp   = '0;
      t_addr;
      t_read;
      t_recv;
      t_foreign;
      stop_test;
   end

   // Watchdog, about twice the expected run
   initial
   begin
      repeat (80000) @(posedge clk_sys_i);
      err_total++;
      stop_test;
   end
endmodule
